// File: inc/urs_pkg.sv
// urs_pkg: offsets, field positions, reset values and widths shared by the serial status block
// assumes a 32-bit AXI4-Lite register bus with each register on one aligned word
package urs_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_STATUS   = 8'h00;
	localparam logic [7:0] OFF_TX_DATA  = 8'h04;
	localparam logic [7:0] OFF_RX_DATA  = 8'h08;
	localparam logic [7:0] OFF_CONTROL  = 8'h0c;
	localparam logic [7:0] OFF_INT_STAT = 8'h10;
	localparam logic [7:0] OFF_INT_MASK = 8'h14;
	localparam int         ADDR_W       = 8;

	// status register fields
	localparam int BIT_DATA_AVAIL = 0;
	localparam int BIT_OVERRUN    = 1;
	localparam int BIT_FRAME_ERR  = 2;
	localparam int BIT_PARITY_ERR = 3;
	localparam int BIT_RX_IDLE    = 4;
	localparam int BIT_ADDR_DET   = 5;

	// control register fields
	localparam int BIT_NINE_BIT   = 0;

	// interrupt status / mask fields
	localparam int BIT_EV_RX_CHAR = 0;
	localparam int BIT_EV_OVERRUN = 1;
	localparam int BIT_EV_CHAR_ERR = 2;
	localparam int BIT_EV_ADDR    = 3;
	localparam int EV_W           = 4;

	// character layout
	localparam int CHAR_W         = 9;
	localparam int NINTH_BIT      = 8;

	// reset values
	localparam logic [EV_W-1:0]   EV_RST   = 4'h0;
	localparam logic [CHAR_W-1:0] CHAR_RST = 9'h000;

	// default receive fifo depth
	localparam int FIFO_DEPTH_DEF = 4;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : urs_pkg

// File: rtl/urs_serial_regs.sv
// urs_serial_regs: status, transmit and receive data registers of an asynchronous serial port
// assumes a receive shifter and a transmit shifter on aclk outside this block, and an AXI4-Lite master
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps

// Function
// R1: address detect acts only in 9-bit mode
// R2: status bit 4 reads receiver idle
// R3: bit 3 shows parity error of head
// R4: bit 2 shows framing error of head
// R5: overrun bit 1 set by hardware, cleared only
// R6: clearing overrun flushes fifo and shift register
// R7: bit 0 high while characters remain unread
// R8: software writes character and ninth bit
// R9: bits 15-9 of data registers read zero
// R10: receive register read-only, zero after reset
// R11: address detect discards characters with ninth clear
module urs_serial_regs #(
	parameter int FIFO_DEPTH = urs_pkg::FIFO_DEPTH_DEF
) (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	// axi4-lite write address
	input  wire logic [urs_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	// axi4-lite read address
	input  wire logic [urs_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	// receive shifter side
	input  wire logic                         rx_char_valid,
	input  wire logic [urs_pkg::CHAR_W-1:0]   rx_char_data,
	input  wire logic                         rx_parity_err,
	input  wire logic                         rx_frame_err,
	input  wire logic                         rx_busy,
	output logic                              receive_shift_register_clear,
	output logic                              nine_bit_mode,
	// transmit shifter side
	output logic [urs_pkg::CHAR_W-1:0]        tx_char_data,
	output logic                              tx_char_valid,
	// interrupt
	output logic                              irq
);
	localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);

	// write channel holding registers
	logic                         aw_full_reg;
	logic [urs_pkg::ADDR_W-1:0]   aw_addr_reg;
	logic                         w_full_reg;
	logic [31:0]                  w_data_reg;
	logic [3:0]                   w_strb_reg;
	logic                         bvalid_reg;
	logic [1:0]                   bresp_reg;
	// read channel registers
	logic                         rvalid_reg;
	logic [31:0]                  rdata_reg;
	logic [1:0]                   rresp_reg;
	// control and status state
	logic                         addr_detect_enable_reg;
	logic                         nine_bit_reg;
	logic                         overrun_error_flag_reg;
	logic [urs_pkg::EV_W-1:0]     int_stat_reg;
	logic [urs_pkg::EV_W-1:0]     int_mask_reg;
	logic [urs_pkg::CHAR_W-1:0]   tx_data_reg;
	logic                         tx_valid_reg;
	logic                         rsr_clear_reg;
	// receive fifo
	logic [urs_pkg::CHAR_W-1:0]   fifo_char [FIFO_DEPTH];
	logic                         fifo_parity_error_flag [FIFO_DEPTH];
	logic                         fifo_framing_error_flag [FIFO_DEPTH];
	logic [PTR_W-1:0]             wr_ptr_reg;
	logic [PTR_W-1:0]             rd_ptr_reg;
	logic [CNT_W-1:0]             count_reg;

	// write decode: the write happens once both address and data are held
	wire                          write_fire   = aw_full_reg && w_full_reg && !bvalid_reg;
	wire                          wr_status    = write_fire && (aw_addr_reg == urs_pkg::OFF_STATUS);
	wire                          wr_tx        = write_fire && (aw_addr_reg == urs_pkg::OFF_TX_DATA);
	wire                          wr_rx        = write_fire && (aw_addr_reg == urs_pkg::OFF_RX_DATA);
	wire                          wr_control   = write_fire && (aw_addr_reg == urs_pkg::OFF_CONTROL);
	wire                          wr_int_stat  = write_fire && (aw_addr_reg == urs_pkg::OFF_INT_STAT);
	wire                          wr_int_mask  = write_fire && (aw_addr_reg == urs_pkg::OFF_INT_MASK);
	wire                          wr_mapped    = wr_status || wr_tx || wr_rx || wr_control || wr_int_stat
	                                             || wr_int_mask;
	wire                          lane0        = w_strb_reg[0];
	wire                          lane1        = w_strb_reg[1];

	// read decode
	wire                          ar_fire      = s_axi_arvalid && s_axi_arready;
	wire                          rd_status    = (s_axi_araddr == urs_pkg::OFF_STATUS);
	wire                          rd_tx        = (s_axi_araddr == urs_pkg::OFF_TX_DATA);
	wire                          rd_rx        = (s_axi_araddr == urs_pkg::OFF_RX_DATA);
	wire                          rd_control   = (s_axi_araddr == urs_pkg::OFF_CONTROL);
	wire                          rd_int_stat  = (s_axi_araddr == urs_pkg::OFF_INT_STAT);
	wire                          rd_int_mask  = (s_axi_araddr == urs_pkg::OFF_INT_MASK);
	wire                          rd_mapped    = rd_status || rd_tx || rd_rx || rd_control || rd_int_stat
	                                             || rd_int_mask;

	// fifo state
	wire                          fifo_empty   = (count_reg == '0);
	wire                          fifo_full    = (count_reg == CNT_FULL);
	wire [urs_pkg::CHAR_W-1:0]    head_char    = fifo_char[rd_ptr_reg];
	wire                          head_parity_error_flag    = fifo_parity_error_flag[rd_ptr_reg] && !fifo_empty;
	wire                          head_framing_error_flag    = fifo_framing_error_flag[rd_ptr_reg] && !fifo_empty;

	// address filter: only effective in 9-bit mode
	wire                          addr_mode    = addr_detect_enable_reg && nine_bit_reg;  // R1
	wire                          is_addr_char = nine_bit_reg && rx_char_data[urs_pkg::NINTH_BIT];
	wire                          char_keep    = !addr_mode || is_addr_char;  // R11
	wire                          rx_arrive    = rx_char_valid && char_keep;

	// overrun clear: a one-to-zero write from software, unless a new overrun lands this cycle
	wire                          overrun_set  = rx_arrive && fifo_full && !overrun_error_flag_reg;  // R5
	wire                          overrun_wclr = wr_status && lane0 && !w_data_reg[urs_pkg::BIT_OVERRUN];
	wire                          flush        = overrun_wclr && overrun_error_flag_reg && !overrun_set;  // R6

	// push while not overrun and not full; pop on a read of the receive register
	wire                          push         = rx_arrive && !fifo_full && !overrun_error_flag_reg && !flush;
	wire                          pop          = ar_fire && rd_rx && !fifo_empty && !flush;

	// status word as read by software
	wire [31:0]                   status_word;
	assign status_word = {26'h0000000,
	                      addr_detect_enable_reg,  // R1
	                      !rx_busy,                // R2
	                      head_parity_error_flag,               // R3
	                      head_framing_error_flag,               // R4
	                      overrun_error_flag_reg,  // R5
	                      !fifo_empty};            // R7

	// receive word: bits 15-9 and above read zero
	wire [31:0]                   rx_word  = {23'h000000, fifo_empty ? urs_pkg::CHAR_RST : head_char};  // R9 R10
	wire [31:0]                   ctl_word = {31'h00000000, nine_bit_reg};
	wire [31:0]                   ist_word = {28'h0000000, int_stat_reg};
	wire [31:0]                   msk_word = {28'h0000000, int_mask_reg};

	// read data selection; the transmit register is write-only and reads zero
	wire [31:0]                   rd_word  = rd_status   ? status_word :
	                                         rd_rx       ? rx_word :
	                                         rd_control  ? ctl_word :
	                                         rd_int_stat ? ist_word :
	                                         rd_int_mask ? msk_word : 32'h00000000;  // R9

	// interrupt events this cycle
	wire [urs_pkg::EV_W-1:0]      events;
	assign events[urs_pkg::BIT_EV_RX_CHAR]  = push;
	assign events[urs_pkg::BIT_EV_OVERRUN]  = overrun_set;
	assign events[urs_pkg::BIT_EV_CHAR_ERR] = push && (rx_parity_err || rx_frame_err);
	assign events[urs_pkg::BIT_EV_ADDR]     = push && addr_mode && is_addr_char;

	// write-one-to-clear, with a new event winning over the clear
	wire [urs_pkg::EV_W-1:0]      ist_clr  = (wr_int_stat && lane0) ? w_data_reg[urs_pkg::EV_W-1:0] : '0;
	wire [urs_pkg::EV_W-1:0]      ist_next = (int_stat_reg & ~ist_clr) | events;

	// axi handshake outputs
	assign s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready  = !w_full_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// block outputs
	assign receive_shift_register_clear = rsr_clear_reg;
	assign nine_bit_mode                = nine_bit_reg;
	assign tx_char_data                 = tx_data_reg;
	assign tx_char_valid                = tx_valid_reg;
	assign irq                          = |(int_stat_reg & int_mask_reg);

	// write address and data capture, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_full_reg  <= 1'b0;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (write_fire) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (write_fire) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	// write response, slave error for an unmapped address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= urs_pkg::RESP_OKAY;
		end else if (write_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_mapped ? urs_pkg::RESP_OKAY : urs_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// read response, registered one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= urs_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_word;
			rresp_reg  <= rd_mapped ? urs_pkg::RESP_OKAY : urs_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// software controls: address detect enable, character width, interrupt mask
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_detect_enable_reg <= 1'b0;
			nine_bit_reg           <= 1'b0;
			int_mask_reg           <= urs_pkg::EV_RST;
		end else begin
			if (wr_status && lane0) begin
				addr_detect_enable_reg <= w_data_reg[urs_pkg::BIT_ADDR_DET];  // R1
			end
			if (wr_control && lane0) begin
				nine_bit_reg <= w_data_reg[urs_pkg::BIT_NINE_BIT];
			end
			if (wr_int_mask && lane0) begin
				int_mask_reg <= w_data_reg[urs_pkg::EV_W-1:0];
			end
		end
	end

	// overrun flag: hardware sets, software may only clear; sticky interrupt status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overrun_error_flag_reg <= 1'b0;
			int_stat_reg           <= urs_pkg::EV_RST;
			rsr_clear_reg          <= 1'b0;
		end else begin
			if (overrun_set) begin
				overrun_error_flag_reg <= 1'b1;  // R5
			end else if (overrun_wclr) begin
				overrun_error_flag_reg <= 1'b0;  // R5
			end
			int_stat_reg  <= ist_next;
			rsr_clear_reg <= flush;  // R6
		end
	end

	// transmit register: character and ninth bit handed to the shifter as a one-cycle pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_data_reg  <= urs_pkg::CHAR_RST;
			tx_valid_reg <= 1'b0;
		end else begin
			tx_valid_reg <= wr_tx && lane0;  // R8
			if (wr_tx && lane0) begin
				tx_data_reg <= {lane1 && w_data_reg[urs_pkg::NINTH_BIT], w_data_reg[7:0]};  // R8
			end
		end
	end

	// receive fifo pointers and occupancy; a flush empties it at once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else if (flush) begin
			wr_ptr_reg <= '0;  // R6
			rd_ptr_reg <= '0;  // R6
			count_reg  <= '0;  // R6
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;  // R7
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;  // R7
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;  // R7
			end
		end
	end

	// receive fifo storage: character with its own error flags, cleared at reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				fifo_char[i] <= urs_pkg::CHAR_RST;  // R10
				fifo_parity_error_flag[i] <= 1'b0;
				fifo_framing_error_flag[i] <= 1'b0;
			end
		end else if (push) begin
			fifo_char[wr_ptr_reg] <= rx_char_data;   // R10
			fifo_parity_error_flag[wr_ptr_reg] <= rx_parity_err;  // R3
			fifo_framing_error_flag[wr_ptr_reg] <= rx_frame_err;   // R4
		end
	end

endmodule // urs_serial_regs

// File: verif/urs_line_model.sv
// urs_line_model: remote serial sender as seen through the receive shifter
// assumes the bench pulses start for one aclk cycle per character
`timescale 1ns/1ps
module urs_line_model #(
	parameter int BITS = 12
) (
	input  wire logic       aclk,
	input  wire logic       start,
	input  wire logic [8:0] ch,
	input  wire logic [1:0] err,
	output logic            rx_char_valid,
	output logic [8:0]      rx_char_data,
	output logic            rx_parity_err,
	output logic            rx_frame_err,
	output logic            rx_busy
);
	int          cnt  = 0;
	logic [10:0] held = '0;
	// shift time counts down; the last count hands the character over
	always @(posedge aclk) begin
		if (start) begin
			held <= {err, ch};
			cnt  <= BITS;
		end else if (cnt != 0)
			cnt <= cnt - 1;
	end
	// outside the hand-over the lines show the inverse of the last value
	assign rx_char_valid = (cnt == 1);
	assign {rx_frame_err, rx_parity_err, rx_char_data} = rx_char_valid ? held : ~held;
	assign rx_busy = (cnt != 0);
endmodule // urs_line_model

// File: verif/urs_serial_regs_chk.sv
// urs_serial_regs_chk: timing and status checks at the serial register block ports
// assumes one clock aclk and the synchronous active-low reset aresetn
`timescale 1ns/1ps
module urs_serial_regs_chk (
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic [urs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic                       rx_char_valid,
	input wire logic                       rx_busy,
	input wire logic                       receive_shift_register_clear,
	input wire logic                       nine_bit_mode,
	input wire logic                       tx_char_valid,
	input wire logic                       irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// read address decode
	wire ar_go   = s_axi_arvalid & s_axi_arready;
	wire stat_ar = s_axi_araddr == urs_pkg::OFF_STATUS;
	wire data_ar = s_axi_araddr == urs_pkg::OFF_RX_DATA || s_axi_araddr == urs_pkg::OFF_TX_DATA;
	a_idle_flag: assert property (ar_go && stat_ar ##1 $stable(rx_busy)
		|-> ##[0:1] (s_axi_rvalid && s_axi_rdata[urs_pkg::BIT_RX_IDLE] != rx_busy)) else $error("idle flag wrong");
	a_avail_after_push: assert property (rx_char_valid && !nine_bit_mode
		##1 ar_go && stat_ar && !receive_shift_register_clear
		|-> ##[1:2] (s_axi_rvalid && (s_axi_rdata[urs_pkg::BIT_DATA_AVAIL] || s_axi_rdata[urs_pkg::BIT_OVERRUN])))
		else $error("data flag low");
	a_data_upper_zero: assert property (ar_go && data_ar
		|-> ##[1:2] (s_axi_rvalid && s_axi_rdata[31:9] == '0)) else $error("data upper bits set");
	a_clear_pulse_once: assert property (receive_shift_register_clear
		|-> $rose(s_axi_bvalid) ##1 !receive_shift_register_clear) else $error("clear pulse wrong");
	a_tx_pulse_once: assert property (tx_char_valid
		|-> $rose(s_axi_bvalid) ##1 !tx_char_valid) else $error("tx pulse wrong");
	a_reset_quiet: assert property ($rose(aresetn)
		|-> !s_axi_rvalid && !s_axi_bvalid && !irq && !tx_char_valid) else $error("busy after reset");
	a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped");
	// main scenarios reached
	c_flush: cover property (receive_shift_register_clear);
	c_tx: cover property (tx_char_valid);
	c_irq: cover property (irq);
	c_busy_read: cover property (ar_go && stat_ar && rx_busy);
endmodule // urs_serial_regs_chk

bind urs_serial_regs urs_serial_regs_chk u_urs_serial_regs_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .rx_char_valid,
	.rx_busy, .receive_shift_register_clear, .nine_bit_mode, .tx_char_valid, .irq);

// File: verif/uart_rx_status_and_data_regs_tb_top.sv
// uart_rx_status_and_data_regs_tb_top: self-checking bench of the serial register block
// assumes urs_line_model on the receive side and the bound checker
`timescale 1ns/1ps
module uart_rx_status_and_data_regs_tb_top;
	logic        aclk = 0, aresetn = 0, start = 0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = '0, seed = 32'd84294;
	logic [3:0]  s_axi_wstrb = '0;
	logic [8:0]  ch = '0, c1, c2;
	logic [1:0]  err = '0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_char_valid;
	wire         rx_parity_err, rx_frame_err, rx_busy, receive_shift_register_clear, nine_bit_mode;
	wire         tx_char_valid, irq;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [8:0]   rx_char_data, tx_char_data;
	logic [33:0] rq[$], bq[$], tq[$];
	int          n_errors = 0, n_tests = 0, k, n_clr = 0;
	urs_serial_regs #(.FIFO_DEPTH(4)) u_urs_serial_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rx_char_valid, .rx_char_data, .rx_parity_err, .rx_frame_err, .rx_busy,
		.receive_shift_register_clear, .nine_bit_mode, .tx_char_data, .tx_char_valid, .irq);
	urs_line_model #(.BITS(12)) u_urs_line_model (.aclk, .start, .ch, .err, .rx_char_valid, .rx_char_data,
		.rx_parity_err, .rx_frame_err, .rx_busy);
	initial forever #50 aclk = ~aclk;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic hang(input int lim);
		if (k >= lim) begin
			n_errors++;
			$display("[FAIL] wait expected answer seen timeout");
			results();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] exp);
		rq.push_back(exp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		k = 0;
		do @(posedge aclk); while (!s_axi_arready && ++k < 50);
		s_axi_arvalid <= 0;
		while (!s_axi_rvalid && ++k < 50) @(posedge aclk);
		s_axi_rready <= 0;
		hang(50);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		bq.push_back({32'h0, resp});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		k = 0;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while ((s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready) && ++k < 50);
		while (!s_axi_bvalid && ++k < 50) @(posedge aclk);
		s_axi_bready <= 0;
		hang(50);
	endtask
	task automatic send(input logic [8:0] c, input logic [1:0] e);
		@(posedge aclk);
		{ch, err, start} <= {c, e, 1'b1};
		@(posedge aclk);
		start <= 0;
	endtask
	task automatic drain;
		k = 0;
		do @(posedge aclk); while (rx_busy && ++k < 100);
		hang(100);
	endtask
	// each answer seen is compared with the oldest note
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front(), "read");
		if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, bq.pop_front(), "bresp");
		if (tx_char_valid) chk({25'h0, tx_char_data}, tq.pop_front(), "tx");
		if (receive_shift_register_clear) n_clr++;  // shift register clear pulses seen
	end
	// main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		rd(urs_pkg::OFF_STATUS, 34'h10);
		rd(urs_pkg::OFF_RX_DATA, 34'h0);
		rd(8'h1c, {urs_pkg::RESP_SLVERR, 32'h0});
		$display("reset values done");
		seed = lfsr(seed);
		c1 = {1'b0, seed[7:0]};
		c2 = {1'b0, seed[15:8]};
		send(c1, 2'h1);
		rd(urs_pkg::OFF_STATUS, 34'h0);
		drain();
		send(c2, 2'h2);
		// the model hands over 12 cycles after start: read status in the cycle right after the push
		repeat (11) @(posedge aclk);
		rd(urs_pkg::OFF_STATUS, 34'h19);
		rd(urs_pkg::OFF_RX_DATA, {25'h0, c1});
		rd(urs_pkg::OFF_STATUS, 34'h15);
		rd(urs_pkg::OFF_RX_DATA, {25'h0, c2});
		rd(urs_pkg::OFF_STATUS, 34'h10);
		$display("head errors done");
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			send({1'b0, seed[7:0]}, 2'h0);
			drain();
		end
		rd(urs_pkg::OFF_STATUS, 34'h13);
		wr(urs_pkg::OFF_STATUS, 32'h0, urs_pkg::RESP_OKAY);
		rd(urs_pkg::OFF_RX_DATA, 34'h0);
		wr(urs_pkg::OFF_STATUS, 32'h2, urs_pkg::RESP_OKAY);
		chk(n_clr, 34'h1, "rsr clear pulses");
		rd(urs_pkg::OFF_STATUS, 34'h10);
		$display("overrun done");
		wr(urs_pkg::OFF_CONTROL, 32'h1, urs_pkg::RESP_OKAY);
		chk({33'h0, nine_bit_mode}, 34'h1, "nine bit mode on");
		wr(urs_pkg::OFF_STATUS, 32'h20, urs_pkg::RESP_OKAY);
		send(9'h055, 2'h0);
		drain();
		rd(urs_pkg::OFF_STATUS, 34'h30);
		send(9'h1a3, 2'h0);
		drain();
		rd(urs_pkg::OFF_RX_DATA, 34'h1a3);
		wr(urs_pkg::OFF_CONTROL, 32'h0, urs_pkg::RESP_OKAY);
		chk({33'h0, nine_bit_mode}, 34'h0, "nine bit mode off");
		send(9'h066, 2'h0);
		drain();
		rd(urs_pkg::OFF_STATUS, 34'h31);
		rd(urs_pkg::OFF_RX_DATA, 34'h066);
		$display("address detect done");
		tq.push_back(34'h1ff);
		wr(urs_pkg::OFF_TX_DATA, 32'hffffffff, urs_pkg::RESP_OKAY);
		rd(urs_pkg::OFF_TX_DATA, 34'h0);
		rd(urs_pkg::OFF_INT_STAT, 34'hf);
		wr(urs_pkg::OFF_INT_STAT, 32'hf, urs_pkg::RESP_OKAY);
		send(9'h0c3, 2'h0);
		drain();
		rd(urs_pkg::OFF_INT_STAT, 34'h1);
		chk({33'h0, irq}, 34'h0, "irq masked");
		wr(urs_pkg::OFF_INT_MASK, 32'h1, urs_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({33'h0, irq}, 34'h1, "irq raised");
		wr(urs_pkg::OFF_INT_STAT, 32'h1, urs_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({33'h0, irq}, 34'h0, "irq cleared");
		$display("transmit and interrupt done");
		results();
	end
endmodule // uart_rx_status_and_data_regs_tb_top
